/* verilog/fsc_fir_stream.sv */
`timescale 1ns/1ps
// Functional notes
// - channel index output names the per-wire channel slot of the current result
// - wire zero results sit in the lowest data bits, next wires above
// - start marker high exactly when channel 0 result is shown
// - end marker high when last channel of a wire is shown
// - two-bit error: none, missing start, missing end, unexpected end or other
// - coefficient output returns memory content at the addressed location
// - read-valid marks cycles where coefficient output holds a true read
// - one multiplier set per wire reused over clock-to-sample-ratio cycles per sample
// - serializer before shared arithmetic, deserializer after it
// - result valid high only while valid result data is presented

module fsc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rstn,
    // fill side
    input  wire logic                     inValid,
    input  wire logic [WIDTH-1:0]         inData,
    output      logic                     inReady,
    // drain side
    output      logic                     outValid,
    output      logic [WIDTH-1:0]         outData,
    input  wire logic                     outReady,
    // fill level
    output      logic [$clog2(DEPTH):0]   level
);
    localparam int PW = $clog2(DEPTH);

    // refuse at elaboration a depth that the pointer wrap cannot serve
    if (DEPTH < 2 || (1 << PW) != DEPTH)
        $error("fifo depth must be a power of two");

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr;
    logic [PW-1:0]    rdPtr;
    logic [PW:0]      count;
    logic [PW-1:0]    next_wrPtr;
    logic [PW-1:0]    next_rdPtr;
    logic [PW:0]      next_count;
    logic             push;
    logic             pop;

    // full and empty come straight from the count
    assign inReady  = (count != (PW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];
    assign level    = count;

    // pointer and count updates
    always_comb
    begin
        push       = inValid && inReady;
        pop        = outValid && outReady;
        next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
        next_count = count;
        if (push && !pop)
            next_count = count + 1'b1;
        else if (pop && !push)
            next_count = count - 1'b1;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    // storage needs no reset: nothing reads a slot before it is written
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wrPtr] <= inData;
    end
endmodule

module fsc_fir_stream #(
    parameter int DW    = fsc_pkg::DW,
    parameter int CW    = fsc_pkg::CW,
    parameter int TAPS  = fsc_pkg::TAPS,
    parameter int CPW   = fsc_pkg::CPW,
    parameter int WIRES = fsc_pkg::WIRES,
    parameter int FOLD  = fsc_pkg::FOLD
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       resetn,
    // sample frames: all channels of one sample period
    input  wire logic                       sinkValid,
    input  wire logic [WIRES*CPW*DW-1:0]    sinkData,
    output      logic                       sinkReady,
    // result stream
    input  wire logic                       sourceReady,
    output      logic                       sourceValid,
    output      logic [fsc_pkg::CHW-1:0]    sourceChannel,
    output      logic [WIRES*DW-1:0]        sourceData,
    output      logic                       sourceSop,
    output      logic                       sourceEop,
    output      logic [1:0]                 sourceError,
    // coefficient port
    input  wire logic [fsc_pkg::AW-1:0]     coefAddr,
    input  wire logic                       coefWe,
    input  wire logic [CW-1:0]              coefInData,
    output      logic                       coefOutValid,
    output      logic [CW-1:0]              coefOutData
);
    localparam int SW   = (FOLD > 1) ? $clog2(FOLD) : 1;
    localparam int ACCW = DW + CW + fsc_pkg::AW;
    localparam int NCH  = WIRES * CPW;
    localparam int LW   = $clog2(fsc_pkg::FIFO_DEPTH) + 1;

    // refuse at elaboration shapes that the shared beat type and slot counter cannot carry
    if (CPW < 1 || CPW > FOLD || TAPS < 2 || WIRES * DW != $bits(fsc_pkg::fsc_beat_t) - fsc_pkg::CHW - 2
        || DW != fsc_pkg::DW || CW != fsc_pkg::CW || TAPS != fsc_pkg::TAPS || CPW != fsc_pkg::CPW)
        $error("fir stream parameters cannot be served");

    // lane k of a packed vector of samples
    function automatic logic signed [DW-1:0] lane(input logic [NCH*DW-1:0] v, input int k);
        return v[k*DW +: DW];
    endfunction

    // reset release through two flops
    logic rstMeta;
    logic rstn;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rstMeta <= 1'b0;
            rstn    <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstn    <= rstMeta;
        end
    end

    // period state, staging, coefficients and history
    logic [SW-1:0]           slot;
    logic                    busy;
    logic                    stageFull;
    logic [NCH*DW-1:0]       stage;
    logic [NCH*DW-1:0]       work;
    logic signed [CW-1:0]    coef [TAPS];
    logic signed [DW-1:0]    hist [NCH][TAPS-1];
    logic [SW-1:0]           next_slot;
    logic                    next_busy;
    logic                    next_stageFull;
    logic [NCH*DW-1:0]       next_stage;
    logic [NCH*DW-1:0]       next_work;
    logic signed [CW-1:0]    next_coef [TAPS];
    logic signed [DW-1:0]    next_hist [NCH][TAPS-1];
    logic                    next_coefOutValid;
    logic [CW-1:0]           next_coefOutData;
    logic                    take;
    logic                    load;
    logic                    fifoPush;
    logic                    fifoReady;
    logic [LW-1:0]           fifoLevel;
    fsc_pkg::fsc_beat_t      pushBeat;
    logic signed [ACCW-1:0]  acc;

    // frames wait in the stage; a period starts only with room for all its beats
    always_comb
    begin
        take           = sinkValid && sinkReady;
        next_slot      = (slot == SW'(FOLD - 1)) ? '0 : slot + 1'b1;
        load           = stageFull && (slot == SW'(FOLD - 1))
                         && (int'(fifoLevel) + int'(fifoPush) <= fsc_pkg::FIFO_DEPTH - CPW);
        next_busy      = (slot == SW'(FOLD - 1)) ? load : busy;
        next_stageFull = (stageFull && !load) || take;
        next_stage     = take ? sinkData : stage;
        next_work      = load ? stage : work;
    end

    // serializer feeds one channel slot per cycle into the shared taps
    always_comb
    begin
        next_hist = hist;
        pushBeat  = '0;
        acc       = '0;
        fifoPush  = busy && (int'(slot) < CPW);
        for (int w = 0; w < WIRES; w++)
        begin
            for (int s = 0; s < CPW; s++)
            begin
                if (int'(slot) == s)
                begin
                    acc = ACCW'(lane(work, w*CPW + s)) * ACCW'(coef[0]);
                    for (int t = 1; t < TAPS; t++)
                        acc = acc + ACCW'(hist[w*CPW + s][t-1]) * ACCW'(coef[t]);
                    pushBeat.data[w*DW +: DW] = acc[fsc_pkg::RESULT_MSB -: DW];
                    if (fifoPush)
                    begin
                        next_hist[w*CPW + s][0] = lane(work, w*CPW + s);
                        for (int t = 1; t < TAPS - 1; t++)
                            next_hist[w*CPW + s][t] = hist[w*CPW + s][t-1];
                    end
                end
            end
        end
        pushBeat.chan = fsc_pkg::CHW'(slot);
        pushBeat.sop  = (slot == '0);
        pushBeat.eop  = (int'(slot) == CPW - 1);
    end

    // coefficient memory: a write shows on the read side one cycle later
    always_comb
    begin
        next_coef = coef;
        if (coefWe)
            next_coef[coefAddr] = coefInData;
        next_coefOutData  = coef[coefAddr];
        next_coefOutValid = !coefWe;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            slot         <= '0;
            busy         <= 1'b0;
            stageFull    <= 1'b0;
            sinkReady    <= 1'b0;
            stage        <= '0;
            work         <= '0;
            coefOutValid <= 1'b0;
            coefOutData  <= '0;
            for (int i = 0; i < TAPS; i++)
                coef[i] <= fsc_pkg::COEF_RESET;
            for (int c = 0; c < NCH; c++)
                for (int t = 0; t < TAPS - 1; t++)
                    hist[c][t] <= '0;
        end
        else
        begin
            slot         <= next_slot;
            busy         <= next_busy;
            stageFull    <= next_stageFull;
            sinkReady    <= !next_stageFull;
            stage        <= next_stage;
            work         <= next_work;
            coefOutValid <= next_coefOutValid;
            coefOutData  <= next_coefOutData;
            coef         <= next_coef;
            hist         <= next_hist;
        end
    end

    // deserializer: results queue here so a slow consumer stalls new periods
    fsc_pkg::fsc_beat_t fifoOut;
    logic               fifoOutValid;
    logic               pop;

    fsc_fifo #(
        .WIDTH ($bits(fsc_pkg::fsc_beat_t)),
        .DEPTH (fsc_pkg::FIFO_DEPTH)
    ) resultFifo (
        .clk      (clk),
        .rstn     (rstn),
        .inValid  (fifoPush),
        .inData   (pushBeat),
        .inReady  (fifoReady),
        .outValid (fifoOutValid),
        .outData  (fifoOut),
        .outReady (pop),
        .level    (fifoLevel)
    );

    // output stage and group tracker; the error code rides with its beat
    fsc_pkg::fsc_trk_t  trk;
    fsc_pkg::fsc_trk_t  next_trk;
    logic               next_sourceValid;
    logic [1:0]         next_sourceError;
    fsc_pkg::fsc_beat_t outBeat;
    fsc_pkg::fsc_beat_t next_outBeat;

    always_comb
    begin
        pop              = fifoOutValid && (!sourceValid || sourceReady);
        next_sourceValid = pop || (sourceValid && !sourceReady);
        next_outBeat     = pop ? fifoOut : outBeat;
        next_sourceError = pop ? fsc_pkg::ERR_NONE : sourceError;
        next_trk         = trk;
        if (pop)
        begin
            case (trk)
                fsc_pkg::TRK_IDLE:
                    if (!fifoOut.sop)
                        next_sourceError = fsc_pkg::ERR_NO_SOP;
                fsc_pkg::TRK_GROUP:
                    if (fifoOut.sop)
                        next_sourceError = fsc_pkg::ERR_NO_EOP;
                default:
                    next_sourceError = fsc_pkg::ERR_BAD;
            endcase
            if (fifoOut.eop != (int'(fifoOut.chan) == CPW - 1))
                next_sourceError = fsc_pkg::ERR_BAD;
            next_trk = fifoOut.eop ? fsc_pkg::TRK_IDLE : fsc_pkg::TRK_GROUP;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            trk         <= fsc_pkg::TRK_IDLE;
            sourceValid <= 1'b0;
            sourceError <= fsc_pkg::ERR_NONE;
            outBeat     <= '0;
        end
        else
        begin
            trk         <= next_trk;
            sourceValid <= next_sourceValid;
            sourceError <= next_sourceError;
            outBeat     <= next_outBeat;
        end
    end

    // outputs are fields of the registered beat
    assign sourceData    = outBeat.data;
    assign sourceChannel = outBeat.chan;
    assign sourceSop     = outBeat.sop;
    assign sourceEop     = outBeat.eop;

    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence sPeriodEnd;
        slot == SW'(FOLD - 1);
    endsequence
    sequence sStalled;
        sourceValid && !sourceReady;
    endsequence

    a_sop_on_zero: assert property (sourceValid |-> (sourceSop == (sourceChannel == '0)))
        else $error("start marker not tied to channel zero");
    a_eop_last_chan: assert property (sourceValid && sourceEop |-> int'(sourceChannel) == CPW - 1)
        else $error("end marker on wrong channel");
    a_error_clean: assert property (sourceValid |-> sourceError == fsc_pkg::ERR_NONE)
        else $error("protocol error on own result stream");
    a_coef_readback: assert property (!coefWe ##1 coefOutValid |-> coefOutData == coef[$past(coefAddr)])
        else $error("coefficient readback mismatch");
    a_coef_valid_gap: assert property (coefWe |=> !coefOutValid ##1 (coefOutValid || $past(coefWe)))
        else $error("read valid wrong around a write");
    a_period_wrap: assert property (sPeriodEnd |=> slot == '0 ##[1:16] sPeriodEnd)
        else $error("period counter does not wrap at fold");
    a_push_slots: assert property (busy && slot == '0 |-> fifoPush && pushBeat.sop ##1 busy)
        else $error("serializer did not start on slot zero");
    a_hold_stall: assert property (sStalled |=> sourceValid && $stable(sourceData) && $stable(sourceChannel))
        else $error("result dropped under back-pressure");
    a_idle_slots: assert property (!busy || int'(slot) >= CPW |-> !fifoPush)
        else $error("result pushed in an unused slot");
    a_no_overflow: assert property (fifoPush |-> fifoReady)
        else $error("result queue overflow");
endmodule

/* verilog/fsc_pkg.sv */
package fsc_pkg;
    // clock and sample rates set the folding factor
    localparam int CLK_HZ     = 25000000;
    localparam int SAMPLE_HZ  = 12500000;
    localparam int FOLD       = CLK_HZ / SAMPLE_HZ;
    // datapath shape
    localparam int DW         = 8;
    localparam int CW         = 8;
    localparam int TAPS       = 4;
    localparam int CPW        = 2;
    localparam int WIRES      = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int CHW        = (CPW > 1) ? $clog2(CPW) : 1;
    localparam int AW         = $clog2(TAPS);
    // result slice: drop the duplicated sign bit of the signed product
    localparam int RESULT_MSB = DW + CW - 2;
    // reset values
    localparam logic [CW-1:0] COEF_RESET = 8'h00;
    // error codes on the result stream
    localparam logic [1:0] ERR_NONE   = 2'h0;
    localparam logic [1:0] ERR_NO_SOP = 2'h1;
    localparam logic [1:0] ERR_NO_EOP = 2'h2;
    localparam logic [1:0] ERR_BAD    = 2'h3;

    // one result beat: all wires of one time slot
    typedef struct packed {
        logic [WIRES*DW-1:0] data;
        logic [CHW-1:0]      chan;
        logic                sop;
        logic                eop;
    } fsc_beat_t;

    // group tracker on the outgoing stream
    typedef enum logic [0:0] {
        TRK_IDLE,
        TRK_GROUP
    } fsc_trk_t;
endpackage

/* tb/fsc_consumer.sv */
`timescale 1ns/1ps
module fsc_consumer (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // pacing: 0 always ready, 1 stalled, 2 every other cycle
    input  wire logic [1:0] mode,
    // result stream
    output      logic       sourceReady
);
    logic phase;

    // free-running phase so mode 2 holds some beats over a stalled edge
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            phase <= 1'b0;
        else
            phase <= ~phase;
    end

    // ready is a plain level, as a slow sink would give it
    assign sourceReady = (mode == 2'h0) | ((mode == 2'h2) & phase);
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
    localparam int NL = fsc_pkg::WIRES * fsc_pkg::CPW;
    logic                      clk;
    logic                      resetn;
    logic                      sinkValid;
    logic [NL*8-1:0]           sinkData;
    logic                      sinkReady;
    logic                      sourceReady;
    logic                      sourceValid;
    logic [fsc_pkg::CHW-1:0]   sourceChannel;
    logic [fsc_pkg::WIRES*8-1:0] sourceData;
    logic                      sourceSop;
    logic                      sourceEop;
    logic [1:0]                sourceError;
    logic [fsc_pkg::AW-1:0]    coefAddr;
    logic                      coefWe;
    logic [7:0]                coefInData;
    logic                      coefOutValid;
    logic [7:0]                coefOutData;
    logic [1:0]                mode;
    int                        errCount;
    int                        checkCount;
    logic signed [7:0]         coefM [fsc_pkg::TAPS];
    logic signed [7:0]         hist [NL][fsc_pkg::TAPS];
    fsc_pkg::fsc_beat_t        expq [$];
    fsc_pkg::fsc_beat_t        eb;

    fsc_fir_stream uut (.clk(clk), .resetn(resetn), .sinkValid(sinkValid), .sinkData(sinkData),
        .sinkReady(sinkReady), .sourceReady(sourceReady), .sourceValid(sourceValid),
        .sourceChannel(sourceChannel), .sourceData(sourceData), .sourceSop(sourceSop),
        .sourceEop(sourceEop), .sourceError(sourceError), .coefAddr(coefAddr), .coefWe(coefWe),
        .coefInData(coefInData), .coefOutValid(coefOutValid), .coefOutData(coefOutData));
    fsc_consumer cons (.clk(clk), .resetn(resetn), .mode(mode), .sourceReady(sourceReady));

    always #20 clk = ~clk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp)
        begin
            errCount++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrapUp();
        $display("checks %0d mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // every accepted beat is judged against the reference queue
    always @(posedge clk)
    begin
        if (resetn === 1'b1 && sourceValid === 1'b1 && sourceReady === 1'b1)
        begin
            if (expq.size() == 0)
                chk("extra beat", 0, 1);
            else
            begin
                eb = expq.pop_front();
                chk("data", eb.data, sourceData);
                chk("channel", eb.chan, sourceChannel);
                chk("sop", eb.sop, sourceSop);
                chk("eop", eb.eop, sourceEop);
                chk("error", fsc_pkg::ERR_NONE, sourceError);
            end
        end
    end

    // reference filter: same taps on every lane, product slice truncated
    task automatic push_frame(input logic [NL*8-1:0] d);
        fsc_pkg::fsc_beat_t b;
        logic signed [31:0] acc;
        for (int k = 0; k < NL; k++)
        begin
            for (int t = fsc_pkg::TAPS - 1; t > 0; t--)
                hist[k][t] = hist[k][t-1];
            hist[k][0] = d[8*k +: 8];
        end
        for (int c = 0; c < fsc_pkg::CPW; c++)
        begin
            b = '0;
            for (int w = 0; w < fsc_pkg::WIRES; w++)
            begin
                acc = 0;
                for (int t = 0; t < fsc_pkg::TAPS; t++)
                    acc += coefM[t] * hist[w*fsc_pkg::CPW+c][t];
                b.data[8*w +: 8] = acc[fsc_pkg::RESULT_MSB -: 8];
            end
            b.chan = c[fsc_pkg::CHW-1:0];
            b.sop = (c == 0);
            b.eop = (c == fsc_pkg::CPW - 1);
            expq.push_back(b);
        end
    endtask

    // one frame, held until taken; lane values mix signs
    task automatic send(input int i);
        logic [NL*8-1:0] d;
        for (int k = 0; k < NL; k++)
            d[8*k +: 8] = 8'(i * 37 + k * 83 + 8'h11);
        push_frame(d);
        @(posedge clk);
        sinkValid <= 1'b1;
        sinkData  <= d;
        for (int n = 0; n <= 200; n++)
        begin
            @(negedge clk);
            if (sinkReady === 1'b1)
                break;
            if (n == 200)
            begin
                chk("frame taken", 1, 0);
                wrapUp();
            end
        end
        @(posedge clk);
        sinkValid <= 1'b0;
        @(negedge clk);
        chk("ready after take", 0, sinkReady);
    endtask

    task automatic drain();
        for (int n = 0; n < 400 && expq.size() != 0; n++)
            @(posedge clk);
        chk("beats left", 0, expq.size());
        if (expq.size() != 0)
            wrapUp();
        repeat (6) @(negedge clk);
        chk("valid after drain", 0, sourceValid);
    endtask

    task automatic wr_coef(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        coefAddr   <= a;
        coefWe     <= 1'b1;
        coefInData <= d;
        coefM[a] = d;
        @(posedge clk);
        coefWe <= 1'b0;
        #1 chk("read valid after write", 0, coefOutValid);
    endtask

    task automatic rd_coef(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        coefAddr <= a;
        @(posedge clk);
        #1 chk("read valid", 1, coefOutValid);
        chk("coef read", exp, coefOutData);
    endtask

    // reset contents, writes one idle cycle apart, read back
    task automatic t_coef();
        for (int a = 0; a < 4; a++)
            rd_coef(a[1:0], fsc_pkg::COEF_RESET);
        wr_coef(2'h0, 8'h40);
        wr_coef(2'h1, 8'hE0);
        wr_coef(2'h2, 8'h10);
        wr_coef(2'h3, 8'h88);
        for (int a = 3; a >= 0; a--)
            rd_coef(a[1:0], coefM[a]);
    endtask

    // frames back to back into a ready sink
    task automatic t_stream();
        @(posedge clk);
        mode <= 2'h0;
        for (int i = 0; i < 6; i++)
            send(i);
        drain();
    endtask

    // stalled sink fills the buffer; head beat must stand
    task automatic t_stall();
        @(posedge clk);
        mode <= 2'h1;
        for (int i = 10; i < 14; i++)
            send(i);
        repeat (8) @(negedge clk);
        chk("held valid", 1, sourceValid);
        chk("held sop", 1, sourceSop);
        chk("nothing consumed", 8, expq.size());
        fork
            begin
                send(14);
                send(15);
            end
            begin
                repeat (20) @(posedge clk);
                mode <= 2'h2;
            end
        join
        drain();
        @(posedge clk);
        mode <= 2'h0;
    endtask

    // new taps apply to later frames only
    task automatic t_retap();
        wr_coef(2'h1, 8'h7F);
        for (int i = 20; i < 23; i++)
            send(i);
        drain();
    endtask

    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        sinkValid = 1'b0;
        sinkData = '0;
        coefAddr = '0;
        coefWe = 1'b0;
        coefInData = 8'h00;
        mode = 2'h0;
        errCount = 0;
        checkCount = 0;
        for (int k = 0; k < NL; k++)
            for (int t = 0; t < fsc_pkg::TAPS; t++)
                hist[k][t] = 8'h00;
        for (int t = 0; t < fsc_pkg::TAPS; t++)
            coefM[t] = fsc_pkg::COEF_RESET;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        t_coef();
        t_stream();
        t_stall();
        t_retap();
        wrapUp();
    end
endmodule
